// ---- rtl/sac_pkg.sv ----
/*
  Shared constants and types for the successive-approximation converter
  control block: register byte offsets, field positions, reset values,
  channel codes, reference codes and the sequencer state type.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package sac_pkg;

  // --------------------------------------------------------------
  // Widths
  // --------------------------------------------------------------
  localparam int RES_W = 10;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  localparam int CHS_W = 6;

  // --------------------------------------------------------------
  // Register byte offsets
  // --------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL_FIRST = 5'h00;
  localparam logic [4:0] OFF_CTRL_SECOND = 5'h04;
  localparam logic [4:0] OFF_RESULT_HIGH = 5'h08;
  localparam logic [4:0] OFF_RESULT_LOW = 5'h0c;
  localparam logic [4:0] OFF_FLAG = 5'h10;
  localparam logic [4:0] OFF_IRQ_EN = 5'h14;
  localparam logic [4:0] OFF_IRQ_CTRL = 5'h18;

  // --------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------
  localparam int POWER_BIT = 0;
  localparam int GO_BIT = 1;
  localparam int CHS_LSB = 2;
  localparam int PREF_LSB = 0;
  localparam int NREF_BIT = 2;
  localparam int CLKSEL_LSB = 4;
  localparam int JUSTIFY_BIT = 7;
  localparam int DONE_FLAG_BIT = 0;
  localparam int DONE_IEN_BIT = 0;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int GIE_BIT = 7;

  // --------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------
  localparam logic [5:0] CHS_RST = 6'h00;
  localparam logic [1:0] PREF_RST = 2'h0;
  localparam logic [2:0] CLKSEL_RST = 3'h0;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h00000000;

  // --------------------------------------------------------------
  // Reference select codes
  // --------------------------------------------------------------
  localparam logic [1:0] PREF_SUPPLY = 2'h0;
  localparam logic [1:0] PREF_PIN = 2'h1;
  localparam logic [1:0] PREF_FVR_2V048 = 2'h2;
  localparam logic [1:0] PREF_FVR_4V096 = 2'h3;

  // Low two clock-select bits both set pick the RC oscillator
  localparam logic [1:0] CLKSEL_RC_LOW = 2'h3;

  // --------------------------------------------------------------
  // Channel codes
  // --------------------------------------------------------------
  localparam logic [5:0] CH_PORTA_BASE = 6'h00;
  localparam logic [5:0] CH_PORTB_BASE = 6'h08;
  localparam logic [5:0] CH_PORTC_BASE = 6'h10;
  localparam logic [5:0] CH_GROUND = 6'h3b;
  localparam logic [5:0] CH_TEMP = 6'h3c;
  localparam logic [5:0] CH_DAC = 6'h3d;
  localparam logic [5:0] CH_FVR = 6'h3e;
  localparam int PORTA_COUNT = 6;

  // --------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int INSTR_NS = 200;
  localparam int INSTR_CYCLES = (INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_HALVES = 3;

  // --------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_DELAY = 3'b010,
    SAC_CONV = 3'b100
  } sac_state_e;

endpackage

// ---- rtl/sac_clkdiv.sv ----
/*
  Conversion clock enable generator. Emits one pulse per half bit period,
  from the system clock divided per the select field, or from the RC tick.
  Assumes rc_half_tick is a one-cycle pulse synchronous to clk_sys.
*/
`timescale 1ns/1ps
module sac_clkdiv (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic run,
  input wire logic [2:0] clk_select,
  input wire logic rc_half_tick,
  output logic half_tick
);

  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic tick_reg;
  logic tick_next;
  logic [5:0] half_len;
  logic [2:0] expo;

  // Divider count in system cycles; tracks any system clock change
  always_comb
  begin
    expo = {sel_hi(clk_select), clk_select[2]};
    half_len = 6'h01 << expo;
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!run)
    begin
      cnt_next = 6'h00;
    end
    else if (clk_select[1:0] == sac_pkg::CLKSEL_RC_LOW)
    begin
      tick_next = rc_half_tick; // see RULE7
    end
    else if (cnt_reg == half_len - 6'h01)
    begin
      cnt_next = 6'h00;
      tick_next = 1'b1; // see RULE10
    end
    else
    begin
      cnt_next = cnt_reg + 6'h01;
    end
  end

  function automatic logic [1:0] sel_hi(input logic [2:0] s);
    sel_hi = s[1:0];
  endfunction

  // Registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign half_tick = tick_reg;

endmodule

// ---- rtl/sac_sar.sv ----
/*
  Successive-approximation engine. Runs 1.5 bit periods of setup, then
  resolves one bit per two half ticks, most significant bit first.
  Assumes comp_high is synchronous and means input is at or above trial.
*/
`timescale 1ns/1ps
module sac_sar #(
  parameter int WIDTH = 10
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic half_tick,
  input wire logic start,
  input wire logic abort,
  input wire logic comp_high,
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] code
);

  localparam int TOTAL = sac_pkg::SETUP_HALVES + 2 * WIDTH;

  initial
  begin
    if (WIDTH < 2 || WIDTH > 12)
    begin
      $error("sac_sar: WIDTH out of range");
    end
  end

  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [WIDTH-1:0] code_reg;
  logic [WIDTH-1:0] code_next;

  // Trial bit set at even offsets, decided two half ticks later
  always_comb
  begin
    int n;
    int j;
    n = 0;
    j = 0;
    busy_next = busy_reg;
    done_next = 1'b0;
    cnt_next = cnt_reg;
    code_next = code_reg;
    if (abort)
    begin
      busy_next = 1'b0;
    end
    else if (start)
    begin
      busy_next = 1'b1;
      cnt_next = 5'h00;
      code_next = '0;
    end
    else if (busy_reg && half_tick)
    begin
      n = int'(cnt_reg) + 1;
      cnt_next = 5'(n);
      if (n >= sac_pkg::SETUP_HALVES && ((n - sac_pkg::SETUP_HALVES) % 2) == 0)
      begin
        j = (n - sac_pkg::SETUP_HALVES) / 2;
        if (j > 0 && !comp_high)
        begin
          code_next[WIDTH-j] = 1'b0; // see RULE1
        end
        if (j < WIDTH)
        begin
          code_next[WIDTH-1-j] = 1'b1;
        end
      end
      if (n == TOTAL)
      begin
        busy_next = 1'b0;
        done_next = 1'b1; // see RULE8
      end
    end
  end

  // Registers
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= 5'h00;
      code_reg <= '0;
    end
    else
    begin
      busy_reg <= busy_next;
      done_reg <= done_next;
      cnt_reg <= cnt_next;
      code_reg <= code_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign code = code_reg;

endmodule

// ---- rtl/sac_top.sv ----
/*
  Control logic for a 10-bit successive-approximation converter: register
  file on Avalon-MM, input and reference selection, conversion sequencing,
  completion flag, sleep handling and wake signalling.
  Assumes synchronous inputs on clk_sys and an analog comparator whose
  decision is valid one half bit period after the trial code changes.
*/
// Functional notes
// RULE1: Ten-bit result by successive approximation, stored in result register pair.
// RULE2: Six-bit channel field in first control register picks the sampled source.
// RULE3: Sources: six port A, four B, eight C, temperature, DAC, reference, ground.
// RULE4: Software waits a settling delay after changing channel before converting.
// RULE5: Two-bit positive reference field: pin, supply, 2.048V, 4.096V on full parts. Code uses 0 for supply, 1 for pin.
// RULE6: Negative reference bit picks external pin or ground.
// RULE7: Three-bit clock field: divide by 2 to 64, or x11 for RC oscillator.
// RULE8: A whole conversion lasts 11.5 bit periods.
// RULE9: Software keeps the bit period inside the allowed range.
// RULE10: Divided clocks follow system clock changes; RC clock does not.
// RULE11: Conversions run during sleep only with the RC clock selected.
// RULE12: Done flag sets at every completion, regardless of interrupt enable.
// RULE13: Hardware never clears the done flag; software does.
// RULE14: Enabled completion in sleep wakes the device.
// RULE15: Wake resumes in-line with global enable clear, vectors with all set.
// RULE16: Justify bit picks left or right placement of the result.
// RULE17: Software waits sensor acquisition time after selecting temperature channel.
// RULE18: Software selects ground before moving to a lower-voltage channel.
// RULE19: Power only while enabled; start cannot be set in the enabling write.
// RULE20: Completion clears start bit, sets flag, updates both result registers.
// RULE21: RC start waits one instruction; other clocks abort on sleep.
// RULE22: Right: low ten bits, zero top; left: top eight high, two in low 7:6.
// RULE23: Reserved reference or channel codes keep the previous valid selection.
`timescale 1ns/1ps
module sac_top #(
  parameter int PORTB_COUNT = 4,
  parameter int PORTC_COUNT = 8,
  parameter bit LOW_VOLTAGE = 1'b0,
  parameter int START_DELAY = sac_pkg::INSTR_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [sac_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sleep_mode,
  input wire logic rc_half_tick,
  input wire logic comp_high,
  output logic [5:0] channel_select,
  output logic [1:0] positive_reference_select,
  output logic negative_reference_select,
  output logic converter_powered,
  output logic sample_connect,
  output logic [sac_pkg::RES_W-1:0] dac_trial_code,
  output logic conversion_active,
  output logic irq_request,
  output logic wake_pulse,
  output logic vector_pulse
);

  initial
  begin
    if (PORTB_COUNT < 0 || PORTB_COUNT > 4 || PORTC_COUNT < 0 || PORTC_COUNT > 8)
    begin
      $error("sac_top: port channel count out of range");
    end
    if (START_DELAY < 1 || START_DELAY > 255)
    begin
      $error("sac_top: START_DELAY out of range");
    end
  end

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  logic waitreq_reg, waitreq_next;
  logic [31:0] rdata_reg, rdata_next;
  logic power_reg, power_next;
  logic go_reg, go_next;
  logic [5:0] chs_reg, chs_next;
  logic [1:0] pref_reg, pref_next;
  logic nref_reg, nref_next;
  logic [2:0] clksel_reg, clksel_next;
  logic justify_reg, justify_next;
  logic [7:0] res_high_reg, res_high_next;
  logic [7:0] res_low_reg, res_low_next;
  logic flag_reg, flag_next;
  logic ien_reg, ien_next;
  logic peripheral_irq_enable_reg, peripheral_irq_enable_next;
  logic gie_reg, gie_next;
  logic sleep_off_reg, sleep_off_next;
  logic irq_reg, irq_next;
  logic wake_reg, wake_next;
  logic vector_reg, vector_next;
  logic powered_reg, powered_next;
  logic sample_reg, sample_next;
  logic [7:0] delay_reg, delay_next;
  sac_pkg::sac_state_e state_reg, state_next;

  logic half_tick;
  logic sar_busy;
  logic sar_done;
  logic [sac_pkg::RES_W-1:0] sar_code;
  logic sar_start;
  logic sar_abort;

  // ------------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------------
  sac_clkdiv u_clkdiv (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(state_reg == sac_pkg::SAC_CONV),
    .clk_select(clksel_reg),
    .rc_half_tick(rc_half_tick),
    .half_tick(half_tick)
  );

  sac_sar #(
    .WIDTH(sac_pkg::RES_W)
  ) u_sar (
    .clk_sys(clk_sys),
    .reset(reset),
    .half_tick(half_tick),
    .start(sar_start),
    .abort(sar_abort),
    .comp_high(comp_high),
    .busy(sar_busy),
    .done(sar_done),
    .code(sar_code)
  );

  // Valid channel codes only
  function automatic logic chan_ok(input logic [5:0] c);
    chan_ok = (c < sac_pkg::CH_PORTA_BASE + 6'(sac_pkg::PORTA_COUNT)) ||
              (c >= sac_pkg::CH_PORTB_BASE &&
               c < sac_pkg::CH_PORTB_BASE + 6'(PORTB_COUNT)) ||
              (c >= sac_pkg::CH_PORTC_BASE &&
               c < sac_pkg::CH_PORTC_BASE + 6'(PORTC_COUNT)) ||
              c == sac_pkg::CH_GROUND || c == sac_pkg::CH_TEMP ||
              c == sac_pkg::CH_DAC || c == sac_pkg::CH_FVR; // see RULE3
  endfunction

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb
  begin
    logic accept;
    logic wr_lo;
    logic [7:0] wd;
    logic rc_sel;
    logic kill;
    accept = (avs_read || avs_write) && !waitreq_reg;
    wr_lo = avs_write && accept && avs_byteenable[0];
    wd = avs_writedata[7:0];
    rc_sel = (clksel_reg[1:0] == sac_pkg::CLKSEL_RC_LOW);
    kill = 1'b0;
    waitreq_next = 1'b1;
    rdata_next = rdata_reg;
    power_next = power_reg;
    go_next = go_reg;
    chs_next = chs_reg;
    pref_next = pref_reg;
    nref_next = nref_reg;
    clksel_next = clksel_reg;
    justify_next = justify_reg;
    res_high_next = res_high_reg;
    res_low_next = res_low_reg;
    flag_next = flag_reg;
    ien_next = ien_reg;
    peripheral_irq_enable_next = peripheral_irq_enable_reg;
    gie_next = gie_reg;
    sleep_off_next = sleep_off_reg && sleep_mode;
    wake_next = 1'b0;
    vector_next = 1'b0;
    delay_next = delay_reg;
    state_next = state_reg;
    sar_start = 1'b0;

    // Bus: one wait cycle, then the access completes
    if ((avs_read || avs_write) && waitreq_reg)
    begin
      waitreq_next = 1'b0;
    end
    if (avs_read && waitreq_reg)
    begin
      rdata_next = sac_pkg::RDATA_UNMAPPED;
      case (avs_address)
        sac_pkg::OFF_CTRL_FIRST:
        begin
          rdata_next[sac_pkg::POWER_BIT] = power_reg;
          rdata_next[sac_pkg::GO_BIT] = go_reg;
          rdata_next[sac_pkg::CHS_LSB +: sac_pkg::CHS_W] = chs_reg;
        end
        sac_pkg::OFF_CTRL_SECOND:
        begin
          rdata_next[sac_pkg::PREF_LSB +: 2] = pref_reg;
          rdata_next[sac_pkg::NREF_BIT] = nref_reg;
          rdata_next[sac_pkg::CLKSEL_LSB +: 3] = clksel_reg;
          rdata_next[sac_pkg::JUSTIFY_BIT] = justify_reg;
        end
        sac_pkg::OFF_RESULT_HIGH: rdata_next[7:0] = res_high_reg;
        sac_pkg::OFF_RESULT_LOW: rdata_next[7:0] = res_low_reg;
        sac_pkg::OFF_FLAG: rdata_next[sac_pkg::DONE_FLAG_BIT] = flag_reg;
        sac_pkg::OFF_IRQ_EN: rdata_next[sac_pkg::DONE_IEN_BIT] = ien_reg;
        sac_pkg::OFF_IRQ_CTRL:
        begin
          rdata_next[sac_pkg::PERIPHERAL_IRQ_ENABLE_BIT] = peripheral_irq_enable_reg;
          rdata_next[sac_pkg::GIE_BIT] = gie_reg;
        end
        default: rdata_next = sac_pkg::RDATA_UNMAPPED;
      endcase
    end

    // Register writes take effect on the completing edge
    if (wr_lo)
    begin
      case (avs_address)
        sac_pkg::OFF_CTRL_FIRST:
        begin
          power_next = wd[sac_pkg::POWER_BIT];
          if (chan_ok(wd[sac_pkg::CHS_LSB +: sac_pkg::CHS_W]))
          begin
            chs_next = wd[sac_pkg::CHS_LSB +: sac_pkg::CHS_W]; // see RULE2, RULE23
          end
          if (!wd[sac_pkg::GO_BIT] || !wd[sac_pkg::POWER_BIT])
          begin
            go_next = 1'b0;
            kill = 1'b1;
          end
          else if (power_reg && !sleep_off_reg)
          begin
            go_next = 1'b1; // see RULE19
          end
        end
        sac_pkg::OFF_CTRL_SECOND:
        begin
          if (!(LOW_VOLTAGE && wd[sac_pkg::PREF_LSB +: 2] == sac_pkg::PREF_FVR_4V096))
          begin
            pref_next = wd[sac_pkg::PREF_LSB +: 2]; // see RULE5, RULE23
          end
          nref_next = wd[sac_pkg::NREF_BIT]; // see RULE6
          clksel_next = wd[sac_pkg::CLKSEL_LSB +: 3]; // see RULE7
          justify_next = wd[sac_pkg::JUSTIFY_BIT]; // see RULE16
        end
        sac_pkg::OFF_FLAG: flag_next = wd[sac_pkg::DONE_FLAG_BIT];
        sac_pkg::OFF_IRQ_EN: ien_next = wd[sac_pkg::DONE_IEN_BIT];
        sac_pkg::OFF_IRQ_CTRL:
        begin
          peripheral_irq_enable_next = wd[sac_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
          gie_next = wd[sac_pkg::GIE_BIT];
        end
        default: ;
      endcase
    end

    // Sleep with a divided clock aborts and powers down
    if (sleep_mode && !rc_sel && (go_reg || state_reg != sac_pkg::SAC_IDLE))
    begin
      kill = 1'b1;
      go_next = 1'b0;
      sleep_off_next = 1'b1; // see RULE11, RULE21
    end
    else if (sleep_mode && !rc_sel)
    begin
      sleep_off_next = 1'b1;
    end
    sar_abort = kill && !sar_done;

    // Sequencer
    case (state_reg)
      sac_pkg::SAC_IDLE:
      begin
        if (go_reg && !kill && power_reg && !sleep_off_reg)
        begin
          if (rc_sel)
          begin
            delay_next = 8'(START_DELAY - 1);
            state_next = sac_pkg::SAC_DELAY; // see RULE21
          end
          else
          begin
            sar_start = 1'b1;
            state_next = sac_pkg::SAC_CONV;
          end
        end
      end
      sac_pkg::SAC_DELAY:
      begin
        if (kill)
        begin
          state_next = sac_pkg::SAC_IDLE;
        end
        else if (delay_reg == 8'h00)
        begin
          sar_start = 1'b1;
          state_next = sac_pkg::SAC_CONV;
        end
        else
        begin
          delay_next = delay_reg - 8'h01;
        end
      end
      sac_pkg::SAC_CONV:
      begin
        if (sar_done || kill)
        begin
          state_next = sac_pkg::SAC_IDLE;
        end
      end
      default: state_next = sac_pkg::SAC_IDLE;
    endcase

    // Completion: clear start, set flag, store formatted result
    if (sar_done && state_reg == sac_pkg::SAC_CONV)
    begin
      go_next = 1'b0; // see RULE20
      flag_next = 1'b1; // see RULE12, RULE13
      if (justify_reg)
      begin
        res_high_next = {6'h00, sar_code[9:8]}; // see RULE22
        res_low_next = sar_code[7:0];
      end
      else
      begin
        res_high_next = sar_code[9:2]; // see RULE16, RULE22
        res_low_next = {sar_code[1:0], 6'h00};
      end
      if (sleep_mode && ien_reg && peripheral_irq_enable_reg)
      begin
        wake_next = 1'b1; // see RULE14
        vector_next = gie_reg; // see RULE15
      end
      else if (sleep_mode)
      begin
        sleep_off_next = 1'b1;
      end
    end

    irq_next = flag_next && ien_next && peripheral_irq_enable_next && gie_next;
    powered_next = power_next && !sleep_off_next; // see RULE19
    sample_next = powered_next && state_next != sac_pkg::SAC_CONV;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      waitreq_reg <= 1'b1;
      rdata_reg <= sac_pkg::RDATA_UNMAPPED;
      power_reg <= 1'b0;
      go_reg <= 1'b0;
      chs_reg <= sac_pkg::CHS_RST;
      pref_reg <= sac_pkg::PREF_RST;
      nref_reg <= 1'b0;
      clksel_reg <= sac_pkg::CLKSEL_RST;
      justify_reg <= 1'b0;
      res_high_reg <= 8'h00;
      res_low_reg <= 8'h00;
      flag_reg <= 1'b0;
      ien_reg <= 1'b0;
      peripheral_irq_enable_reg <= 1'b0;
      gie_reg <= 1'b0;
      sleep_off_reg <= 1'b0;
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
      vector_reg <= 1'b0;
      powered_reg <= 1'b0;
      sample_reg <= 1'b0;
      delay_reg <= 8'h00;
      state_reg <= sac_pkg::SAC_IDLE;
    end
    else
    begin
      waitreq_reg <= waitreq_next;
      rdata_reg <= rdata_next;
      power_reg <= power_next;
      go_reg <= go_next;
      chs_reg <= chs_next;
      pref_reg <= pref_next;
      nref_reg <= nref_next;
      clksel_reg <= clksel_next;
      justify_reg <= justify_next;
      res_high_reg <= res_high_next;
      res_low_reg <= res_low_next;
      flag_reg <= flag_next;
      ien_reg <= ien_next;
      peripheral_irq_enable_reg <= peripheral_irq_enable_next;
      gie_reg <= gie_next;
      sleep_off_reg <= sleep_off_next;
      irq_reg <= irq_next;
      wake_reg <= wake_next;
      vector_reg <= vector_next;
      powered_reg <= powered_next;
      sample_reg <= sample_next;
      delay_reg <= delay_next;
      state_reg <= state_next;
    end
  end

  // Outputs
  assign avs_waitrequest = waitreq_reg;
  assign avs_readdata = rdata_reg;
  assign channel_select = chs_reg;
  assign positive_reference_select = pref_reg;
  assign negative_reference_select = nref_reg;
  assign converter_powered = powered_reg;
  assign sample_connect = sample_reg;
  assign dac_trial_code = sar_code;
  assign conversion_active = sar_busy;
  assign irq_request = irq_reg;
  assign wake_pulse = wake_reg;
  assign vector_pulse = vector_reg;

endmodule

// ---- tb/sac_analog_model.sv ----
/* Analog side model: comparator against a set input level, RC half tick.
   Assumes the trial code is registered on clk_sys. */
`timescale 1ns/1ps
module sac_analog_model (
  input wire logic clk_sys,
  input wire logic [9:0] level,
  input wire logic [9:0] dac_trial_code,
  output logic comp_high,
  output logic rc_half_tick
);
  logic [1:0] rc_cnt_reg = 2'h0;
  // Comparator, input at or above the trial code
  assign comp_high = (level >= dac_trial_code);
  // RC oscillator, one pulse every third cycle
  always @(posedge clk_sys)
  begin
    rc_cnt_reg <= (rc_cnt_reg == 2'h2) ? 2'h0 : rc_cnt_reg + 2'h1;
  end
  assign rc_half_tick = (rc_cnt_reg == 2'h2);
endmodule

// ---- tb/sac_checker.sv ----
/* Assertions on the bus handshake and conversion outputs of sac_top.
   Bound to sac_top and sees its ports only. */
`timescale 1ns/1ps
module sac_checker (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic converter_powered,
  input wire logic sample_connect,
  input wire logic [sac_pkg::RES_W-1:0] dac_trial_code,
  input wire logic conversion_active,
  input wire logic wake_pulse,
  input wire logic vector_pulse
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // Request waiting, then one-cycle answer
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_req |=> s_ans)
    else $error("bus answer wrong");
  a_bus_quiet: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer without request");
  a_active_power: assert property (conversion_active[*2] |-> converter_powered)
    else $error("converting unpowered");
  a_hold_open: assert property (conversion_active[*2] |-> !sample_connect)
    else $error("sampling while converting");
  a_off_open: assert property (!converter_powered[*2] |-> !sample_connect)
    else $error("sampling while off");
  a_trial_start: assert property ($rose(conversion_active) |-> dac_trial_code == '0)
    else $error("trial not cleared at start");
  a_wake_pulse: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse too long");
  a_vector_pulse: assert property (vector_pulse |=> !vector_pulse)
    else $error("vector pulse too long");
endmodule
bind sac_top sac_checker i_sac_checker (.clk_sys(clk_sys), .reset(reset),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .converter_powered(converter_powered), .sample_connect(sample_connect),
  .dac_trial_code(dac_trial_code), .conversion_active(conversion_active),
  .wake_pulse(wake_pulse), .vector_pulse(vector_pulse));

// ---- tb/testbench.sv ----
/* Self-checking bench for sac_top: register access, conversions on seven of
   the eight clock selects (not 3'h7) and both formats, flag and interrupt request.
   Assumes sac_analog_model as the analog side. */
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0, slp = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdata, wd;
  logic avs_waitrequest, comp_high, rc_half_tick, irq_request, nref, wake_pulse, vector_pulse;
  logic [1:0] pref;
  logic [9:0] level = 10'h000;
  logic [9:0] dac_trial_code;
  logic [5:0] channel_select;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [2:0] codes[7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  int n_mismatch = 0;
  int check_count = 0;
  int n;
  always #25 clk_sys = ~clk_sys;
  sac_top i_sac_top (.clk_sys(clk_sys), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sleep_mode(slp), .rc_half_tick(rc_half_tick), .comp_high(comp_high),
    .channel_select(channel_select), .positive_reference_select(pref),
    .negative_reference_select(nref), .converter_powered(), .sample_connect(),
    .dac_trial_code(dac_trial_code), .conversion_active(), .irq_request(irq_request),
    .wake_pulse(wake_pulse), .vector_pulse(vector_pulse));
  sac_analog_model i_sac_analog_model (.clk_sys(clk_sys), .level(level),
    .dac_trial_code(dac_trial_code), .comp_high(comp_high), .rc_half_tick(rc_half_tick));
  task automatic stop_test;
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One access, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_sys);
    avs_write <= w;
    avs_read <= ~w;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    if (k >= 50)
    begin
      n_mismatch++;
      stop_test();
    end
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    acc(1'b0, a, 32'h0);
  endtask
  // Each completed read retires the oldest note
  always @(negedge clk_sys)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      check(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
  end
  // Main sequence
  initial
  begin
    void'($urandom(32'h270f));
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rd(5'h00, 32'h0, 32'hff);
    rd(5'h1c, 32'h0, 32'hffffffff);
    acc(1'b1, 5'h00, 32'h03);
    rd(5'h00, 32'h01, 32'hff);
    acc(1'b1, 5'h00, 32'hf1);
    acc(1'b1, 5'h00, 32'h19);
    rd(5'h00, 32'hf1, 32'hff);
    check({26'h0, channel_select}, 32'h3c);
    for (int i = 0; i < 14; i++)
    begin
      level <= 10'($urandom % 1024);
      wd = {24'h0, i < 7, codes[i % 7], 1'b0, i[0], 2'(i)};
      acc(1'b1, 5'h04, wd);
      rd(5'h04, wd, 32'hff);
      check({29'h0, nref, pref}, {29'h0, wd[2:0]});
      acc(1'b1, 5'h10, 32'h0);
      acc(1'b1, 5'h00, 32'hf3);
      n = 0;
      rdata = 32'h2;
      while (rdata[1] && n < 400)
      begin
        rd(5'h00, 32'h1, 32'h1);
        n++;
      end
      if (n >= 400)
      begin
        n_mismatch++;
        stop_test();
      end
      rd(5'h08, i < 7 ? 32'(level >> 8) : 32'(level >> 2), 32'hff);
      rd(5'h0c, i < 7 ? 32'(level[7:0]) : 32'({level[1:0], 6'h00}), 32'hff);
      rd(5'h10, 32'h1, 32'h1);
    end
    acc(1'b1, 5'h14, 32'h1);
    acc(1'b1, 5'h18, 32'hc0);
    repeat (3) @(negedge clk_sys);
    check({31'h0, irq_request}, 32'h1);
    acc(1'b1, 5'h10, 32'h0);
    rd(5'h10, 32'h0, 32'h1);
    check({31'h0, irq_request}, 32'h0);
    acc(1'b1, 5'h00, 32'hf3);
    slp <= 1'b1;
    for (n = 0; n < 400 && wake_pulse !== 1'b1; n++)
      @(posedge clk_sys);
    check({30'h0, wake_pulse, vector_pulse}, 32'h3);
    stop_test();
  end
endmodule
